//--- tlpi_pkg.sv
// Package with constants, register map and carrier types of the two-level interrupt controller.
// ==========================================================================
package tlpi_pkg;

   // ========================================================================
   // Sizes and vectors
   localparam int NSRC = 8;
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;

   // ========================================================================
   // Register map (byte addresses on APB)
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_RSTCTL = 12'h004;
   localparam logic [11:0] OFS_FLAG = 12'h008;
   localparam logic [11:0] OFS_ENA = 12'h00c;
   localparam logic [11:0] OFS_PRIO = 12'h010;
   localparam logic [11:0] OFS_PERIPH = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;

   // ========================================================================
   // Field positions and reset values
   localparam int BIT_GIE_HIGH = 7;
   localparam int BIT_GIE_LOW = 6;
   localparam int BIT_PRIO_ON = 7;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_FLAG = 8'h00;
   localparam logic [7:0] RST_ENA = 8'h00;
   localparam logic [7:0] RST_PRIO = 8'hff;
   localparam logic [7:0] RST_PERIPH = 8'hf0;

   // ========================================================================
   // Carrier types
   typedef struct packed {
      logic valid;
      logic high;
      logic [20:0] vector;
   } tlpi_vec_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tlpi_apb_req_t;

endpackage : tlpi_pkg

//--- tlpi_ctrl.sv
// Two-level priority interrupt controller with APB register access.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tlpi_ctrl
   import tlpi_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // APB slave
   input wire tlpi_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt sources: in-domain pulses and external pins
   input wire logic [NSRC-1:0] src_event,
   input wire logic [NSRC-1:0] src_is_pin,
   // Core sequencer
   input wire logic [20:0] return_pc,
   input wire logic return_from_irq_instr,
   input wire logic vector_taken,
   output tlpi_vec_t vec_out,
   output logic stack_push,
   output logic [20:0] stack_data,
   output logic in_high_isr,
   output logic in_low_isr
);

   // ========================================================================
   // Register state
   logic [7:0] main_irq_control_reg_q, main_irq_control_reg_d;
   logic [7:0] flag_q, flag_d, ena_q, ena_d, prio_q, prio_d, periph_q, periph_d;
   logic priority_levels_on_q, priority_levels_on_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   // Pin synchronisers and edge detection.
   logic [NSRC-1:0] sync1_q, sync2_q, sync3_q, pin_rise;
   // Service state.
   logic hi_act_q, hi_act_d, lo_act_q, lo_act_d;
   tlpi_vec_t vec_q, vec_d;
   logic push_q, push_d;
   logic [20:0] sdata_q, sdata_d;

   logic global_high_level_enable, global_low_level_enable;
   logic wr_acc, rd_acc, addr_ok;
   logic [7:0] hi_req, lo_req;
   logic hi_go, lo_go;
   logic apb_acc, ret_hi, ret_lo, take_vec;
   logic [NSRC-1:0] sync1_d, sync2_d, sync3_d;

   assign global_high_level_enable = main_irq_control_reg_q[BIT_GIE_HIGH];
   assign global_low_level_enable = main_irq_control_reg_q[BIT_GIE_LOW];

   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == OFS_CTRL) || (a == OFS_RSTCTL) || (a == OFS_FLAG) ||
                   (a == OFS_ENA) || (a == OFS_PRIO) || (a == OFS_PERIPH) ||
                   (a == OFS_STATUS);
   endfunction : known_addr

   // Both levels build their entry the same way, so one place holds the vector choice.
   function automatic tlpi_vec_t entry_vec(input logic high);
      entry_vec.valid = 1'b1;
      entry_vec.high = high;
      entry_vec.vector = high ? VEC_HIGH : VEC_LOW;
   endfunction : entry_vec

   // ========================================================================
   // Pin inputs pass two flops; the edge is taken between the second and third.
   always_comb
   begin
      sync1_d = src_event & src_is_pin;
      sync2_d = sync1_q;
      sync3_d = sync2_q;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
      end
   end
   // The last stage idles low after reset like the pins, so no false edge follows reset.
   assign pin_rise = sync2_q & ~sync3_q;

   // ========================================================================
   // Request qualification. Pin events arrive after the synchroniser, so a pin
   // event reaches the vector output three cycles later plus one for acceptance.
   always_comb
   begin
      hi_req = '0;
      lo_req = '0;
      if (priority_levels_on_q)
      begin
         hi_req = flag_q & ena_q & prio_q & {8{global_high_level_enable}};
         lo_req = flag_q & ena_q & ~prio_q & {8{global_low_level_enable}};
      end
      else
      begin
         // Priority bits are ignored and everything uses the high path.
         hi_req = flag_q & ena_q & {8{global_high_level_enable}}
                  & (~periph_q | {8{global_low_level_enable}});
      end
   end
   // high is not blocked by a running low routine.
   assign hi_go = (|hi_req) && !hi_act_q && !vec_q.valid;
   assign lo_go = (|lo_req) && !hi_act_q && !lo_act_q && !hi_go && !vec_q.valid;

   // ========================================================================
   // APB access decode. An access is taken once, at the first edge of its
   // access phase; the answer follows one cycle later.
   assign apb_acc = apb_req.psel && apb_req.penable && !pready_q;
   assign wr_acc = apb_acc && apb_req.pwrite;
   assign rd_acc = apb_acc && !apb_req.pwrite;
   assign addr_ok = known_addr(apb_req.paddr);

   // ========================================================================
   // Service decisions shared by the control and service groups. A return
   // leaves the high level first when both levels are active.
   assign ret_hi = return_from_irq_instr && hi_act_q;
   assign ret_lo = return_from_irq_instr && !hi_act_q && lo_act_q;
   assign take_vec = vec_q.valid && vector_taken;

   // ========================================================================
   // APB response group.
   always_comb
   begin
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (apb_acc)
      begin
         pready_d = 1'b1;
         pslverr_d = !addr_ok;
      end
      if (rd_acc)
      begin
         unique case (apb_req.paddr)
            OFS_CTRL: prdata_d = {24'h000000, main_irq_control_reg_q};
            OFS_RSTCTL: prdata_d = {24'h000000, priority_levels_on_q, 7'h00};
            OFS_FLAG: prdata_d = {24'h000000, flag_q};
            OFS_ENA: prdata_d = {24'h000000, ena_q};
            OFS_PRIO: prdata_d = {24'h000000, prio_q};
            OFS_PERIPH: prdata_d = {24'h000000, periph_q};
            OFS_STATUS: prdata_d = {30'h0, hi_act_q, lo_act_q};
            default: prdata_d = 32'h00000000;
         endcase
      end
      // An error answer carries zero data for writes too, so stale read data
      // never rides along with it.
      if (apb_acc && !addr_ok)
      begin
         prdata_d = 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ========================================================================
   // Control group: global enables and the priority mode bit.
   always_comb
   begin
      main_irq_control_reg_d = main_irq_control_reg_q;
      priority_levels_on_d = priority_levels_on_q;
      if (wr_acc)
      begin
         unique case (apb_req.paddr)
            OFS_CTRL: main_irq_control_reg_d = apb_req.pwdata[7:0];
            OFS_RSTCTL: priority_levels_on_d = apb_req.pwdata[BIT_PRIO_ON];
            default: ;
         endcase
      end
      // Return from service: reopen the enable of the level being left.
      if (ret_hi)
      begin
         main_irq_control_reg_d[BIT_GIE_HIGH] = 1'b1;
      end
      if (ret_lo)
      begin
         main_irq_control_reg_d[BIT_GIE_LOW] = 1'b1;
      end
      // Acceptance comes last, so it wins over a software write in the same cycle.
      if (hi_go)
      begin
         main_irq_control_reg_d[BIT_GIE_HIGH] = 1'b0;
      end
      else if (lo_go)
      begin
         main_irq_control_reg_d[BIT_GIE_LOW] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         main_irq_control_reg_q <= RST_CTRL;
         priority_levels_on_q <= 1'b0;
      end
      else
      begin
         main_irq_control_reg_q <= main_irq_control_reg_d;
         priority_levels_on_q <= priority_levels_on_d;
      end
   end

   // ========================================================================
   // Source group: flag, enable, priority and peripheral mask bits.
   always_comb
   begin
      flag_d = flag_q;
      ena_d = ena_q;
      prio_d = prio_q;
      periph_d = periph_q;
      if (wr_acc)
      begin
         unique case (apb_req.paddr)
            OFS_FLAG: flag_d = apb_req.pwdata[7:0];
            OFS_ENA: ena_d = apb_req.pwdata[7:0];
            OFS_PRIO: prio_d = apb_req.pwdata[7:0];
            OFS_PERIPH: periph_d = apb_req.pwdata[7:0];
            default: ;
         endcase
      end
      // Hardware sets win over a software clear in the same cycle.
      flag_d = flag_d | (src_event & ~src_is_pin) | pin_rise;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flag_q <= RST_FLAG;
         ena_q <= RST_ENA;
         prio_q <= RST_PRIO;
         periph_q <= RST_PERIPH;
      end
      else
      begin
         flag_q <= flag_d;
         ena_q <= ena_d;
         prio_q <= prio_d;
         periph_q <= periph_d;
      end
   end

   // ========================================================================
   // Service group: active levels, pending vector and stack push.
   always_comb
   begin
      hi_act_d = hi_act_q;
      lo_act_d = lo_act_q;
      vec_d = vec_q;
      push_d = 1'b0;
      sdata_d = sdata_q;
      if (ret_hi)
      begin
         hi_act_d = 1'b0;
      end
      if (ret_lo)
      begin
         lo_act_d = 1'b0;
      end
      // The vector stands until the core takes it; a new entry waits for that.
      if (take_vec)
      begin
         vec_d.valid = 1'b0;
      end
      // A high entry may start while a low routine runs; the low level stays active.
      if (hi_go)
      begin
         hi_act_d = 1'b1;
         vec_d = entry_vec(1'b1);
         push_d = 1'b1;
         sdata_d = return_pc;
      end
      else if (lo_go)
      begin
         lo_act_d = 1'b1;
         vec_d = entry_vec(1'b0);
         push_d = 1'b1;
         sdata_d = return_pc;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hi_act_q <= 1'b0;
         lo_act_q <= 1'b0;
         vec_q <= '0;
         push_q <= 1'b0;
         sdata_q <= 21'h000000;
      end
      else
      begin
         hi_act_q <= hi_act_d;
         lo_act_q <= lo_act_d;
         vec_q <= vec_d;
         push_q <= push_d;
         sdata_q <= sdata_d;
      end
   end

   // ========================================================================
   // Outputs
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign vec_out = vec_q;
   assign stack_push = push_q;
   assign stack_data = sdata_q;
   assign in_high_isr = hi_act_q;
   assign in_low_isr = lo_act_q;

endmodule : tlpi_ctrl

//--- tlpi_checker.sv
// Port timing checker for the two-level interrupt controller.
`timescale 1ns/1ps
module tlpi_checker
   import tlpi_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register bus
   input wire tlpi_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core side
   input wire logic [20:0] return_pc,
   input wire logic return_from_irq_instr,
   input wire logic vector_taken,
   input wire tlpi_vec_t vec_out,
   input wire logic stack_push,
   input wire logic [20:0] stack_data,
   input wire logic in_high_isr,
   input wire logic in_low_isr
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ==========
   // Properties
   a_apb_wait: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
      else $error("pready late");
   a_err_resp: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   a_vec_addr: assert property (vec_out.valid |-> vec_out.vector == (vec_out.high ? VEC_HIGH : VEC_LOW))
      else $error("wrong vector");
   a_push_edge: assert property (stack_push |-> $rose(vec_out.valid))
      else $error("push without new vector");
   a_push_data: assert property (stack_push |-> stack_data == $past(return_pc))
      else $error("wrong pushed address");
   a_vec_hold: assert property (vec_out.valid && !vector_taken |=> vec_out.valid && $stable(vec_out))
      else $error("vector dropped");
   a_low_blocked: assert property ($rose(in_low_isr) |-> !in_high_isr && !$past(in_high_isr))
      else $error("low entered under high");
   a_ret_leave: assert property (return_from_irq_instr && in_high_isr |=> !in_high_isr)
      else $error("high level kept");
   c_preempt: cover property (in_low_isr && $rose(in_high_isr));
   c_low_vec: cover property (stack_push && !vec_out.high);
   c_err: cover property (pslverr);
endmodule : tlpi_checker

bind tlpi_ctrl tlpi_checker u_chk (.sys_clk, .rstn, .apb_req, .prdata, .pready, .pslverr,
   .return_pc, .return_from_irq_instr, .vector_taken, .vec_out, .stack_push, .stack_data,
   .in_high_isr, .in_low_isr);

//--- tlpi_core_model.sv
// Core sequencer model that takes vectors and supplies return addresses.
`timescale 1ns/1ps
module tlpi_core_model
   import tlpi_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Controller side
   input wire tlpi_vec_t vec_out,
   output logic vector_taken,
   output logic [20:0] return_pc
);
   logic [1:0] wait_q;
   // The take delay swings between 1 and 3 cycles, so pending vectors must hold.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         {wait_q, vector_taken, return_pc} <= '0;
      else
      begin
         return_pc <= return_pc + 21'h4;
         wait_q <= (vec_out.valid && !vector_taken) ? wait_q + 2'h1 : 2'h0;
         vector_taken <= vec_out.valid && !vector_taken && wait_q >= {return_pc[4], 1'b0};
      end
   end
endmodule : tlpi_core_model

//--- testbench.sv
// Self-checking testbench of the two-level interrupt controller.
`timescale 1ns/1ps
module testbench
   import tlpi_pkg::*;
;
   logic sys_clk, rstn, ret_i, taken, pready, pslverr, push, in_h, in_l, err;
   logic [NSRC-1:0] ev, pin;
   logic [20:0] rpc, sdata;
   logic [31:0] prdata, rd;
   tlpi_apb_req_t apb_req;
   tlpi_vec_t vo;
   int n_fail, checks_done, cyc, lat;
   tlpi_ctrl u_dut (.sys_clk, .rstn, .apb_req, .prdata, .pready, .pslverr, .src_event(ev),
      .src_is_pin(pin), .return_pc(rpc), .return_from_irq_instr(ret_i), .vector_taken(taken),
      .vec_out(vo), .stack_push(push), .stack_data(sdata), .in_high_isr(in_h), .in_low_isr(in_l));
   tlpi_core_model u_core (.sys_clk, .rstn, .vec_out(vo), .vector_taken(taken), .return_pc(rpc));
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // ==========
   // Tasks
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask : apb
   task automatic rreg(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", rd, e);
   endtask : rreg
   task automatic pulse(input logic [7:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= '0;
   endtask : pulse
   task automatic ret();
      @(posedge sys_clk);
      ret_i <= 1'b1;
      @(posedge sys_clk);
      ret_i <= 1'b0;
   endtask : ret
   task automatic isr(input logic [20:0] v, input logic h, input logic l);
      lat = 0;
      do
      begin
         @(negedge sys_clk);
         lat++;
      end
      while (push !== 1'b1 && lat < 12);
      chk("push", 32'(push), 32'h1);
      chk("vector", 32'(vo.vector), 32'(v));
      chk("levels", 32'({in_h, in_l}), 32'({h, l}));
      chk("pushed address", 32'(sdata), 32'(rpc - 21'h4));
   endtask : isr
   task automatic quiet();
      repeat (8) @(negedge sys_clk);
      chk("idle", 32'(vo.valid), 32'h0);
   endtask : quiet
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         conclude();
      end
   end
   // ==========
   // Tests
   initial
   begin
      {rstn, ret_i, ev, n_fail, checks_done, cyc} = '0;
      apb_req = '0;
      pin = 8'h04;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rreg(OFS_RSTCTL, 32'h0);
      rreg(OFS_PRIO, 32'hff);
      rreg(OFS_PERIPH, 32'hf0);
      apb(1'b1, 12'h01c, 32'h5);
      chk("slverr", 32'(err), 32'h1);
      apb(1'b1, OFS_STATUS, 32'h3);
      rreg(OFS_STATUS, 32'h0);
      pulse(8'h01);
      rreg(OFS_FLAG, 32'h1);
      quiet();
      apb(1'b1, OFS_FLAG, 32'h0);
      $display("test reset and polling done");
      apb(1'b1, OFS_RSTCTL, 32'h80);
      apb(1'b1, OFS_PRIO, 32'h01);
      apb(1'b1, OFS_ENA, 32'h03);
      apb(1'b1, OFS_CTRL, 32'hc0);
      pulse(8'h02);
      isr(VEC_LOW, 1'b0, 1'b1);
      rreg(OFS_CTRL, 32'h80);
      pulse(8'h01);
      isr(VEC_HIGH, 1'b1, 1'b1);
      rreg(OFS_CTRL, 32'h0);
      apb(1'b1, OFS_FLAG, 32'h0);
      ret();
      rreg(OFS_CTRL, 32'h80);
      ret();
      rreg(OFS_CTRL, 32'hc0);
      pulse(8'h03);
      isr(VEC_HIGH, 1'b1, 1'b0);
      rreg(OFS_FLAG, 32'h3);
      quiet();
      apb(1'b1, OFS_FLAG, 32'h2);
      ret();
      isr(VEC_LOW, 1'b0, 1'b1);
      apb(1'b1, OFS_FLAG, 32'h0);
      ret();
      apb(1'b1, OFS_ENA, 32'h02);
      pulse(8'h01);
      quiet();
      apb(1'b1, OFS_CTRL, 32'h80);
      pulse(8'h02);
      quiet();
      $display("test priority mode done");
      apb(1'b1, OFS_FLAG, 32'h0);
      apb(1'b1, OFS_RSTCTL, 32'h0);
      apb(1'b1, OFS_PRIO, 32'h0);
      apb(1'b1, OFS_ENA, 32'h16);
      pulse(8'h10);
      quiet();
      apb(1'b1, OFS_FLAG, 32'h0);
      pulse(8'h02);
      isr(VEC_HIGH, 1'b1, 1'b0);
      rreg(OFS_CTRL, 32'h0);
      apb(1'b1, OFS_FLAG, 32'h0);
      ret();
      rreg(OFS_CTRL, 32'h80);
      @(posedge sys_clk);
      ev[2] <= 1'b1;
      isr(VEC_HIGH, 1'b1, 1'b0);
      chk("pin latency", 32'(lat - 1 inside {[3:4]}), 32'h1);
      $display("test compatibility mode done");
      conclude();
   end
endmodule : testbench
